// ==== hdl/timer0_ctrl_flags_regs.v ====
`timescale 1ns/1ps
`default_nettype none
`include "timer0_consts.vh"
// Behaviour
// [R01] Force bit applies compare action, non-PWM only
// [R02] Forced compare sets no flag, no clear
// [R03] Force bits read back as zero
// [R04] Software keeps force bits zero in PWM
// [R05] Clock select: stop, prescaler taps, pin
// [R06] Pin edges count even when pin output
// [R07] Counter read/write; write blocks next match
// [R08] Compare registers matched continuously with counter
// [R09] Request needs enable, flag and global bit
// [R10] Compare A flag: set on match, clear
// [R11] Compare B flag: set on match, clear
// [R12] Overflow flag set per wave mode
// [R13] Reserved bits read as zero
// [R14] Control B holds wave msb and select
// [R15] Three wave bits choose counting mode
// [R16] Hardware set wins over software clear
module timer0_ctrl_flags_regs (
   input  wire       i_core_clk,                 // Core clock, 250 MHz
   input  wire       i_reset,                    // Async reset, high
   input  wire [7:0] i_addr,                     // Register address
   input  wire [7:0] i_wdata,                    // Write data
   input  wire       i_wr,                       // Write strobe
   input  wire       i_rd,                       // Read strobe
   output reg  [7:0] o_rdata,                    // Read data, next cycle
   input  wire [1:0] i_out_mode_a,               // Output mode channel A
   input  wire [1:0] i_out_mode_b,               // Output mode channel B
   input  wire [1:0] i_wave_mode_low,            // Low wave-mode bits
   input  wire       i_global_irq_en,            // Global interrupt bit
   input  wire       i_vec_ack_a,                // Compare A vector taken
   input  wire       i_vec_ack_b,                // Compare B vector taken
   input  wire       i_vec_ack_ovf,              // Overflow vector taken
   input  wire       i_ext_count_pin,            // External count pin
   output reg        o_wave_out_a,               // Waveform output A
   output reg        o_wave_out_b,               // Waveform output B
   output wire       o_wave_en_a,                // Output A connected
   output wire       o_wave_en_b,                // Output B connected
   output wire       o_irq_cmp_a,                // Compare A request
   output wire       o_irq_cmp_b,                // Compare B request
   output wire       o_irq_ovf,                  // Overflow request
   output wire       o_irq                       // Combined interrupt level
);
   // ==================================================================
   // Registers and state
   reg  [7:0] counter_value;                     // Counter
   reg  [7:0] compare_value_a;                   // Compare A
   reg  [7:0] compare_value_b;                   // Compare B
   reg        wave_mode_msb;                     // Wave mode bit 2
   reg  [2:0] clk_source_sel;                    // Clock select
   reg  [7:0] timer_irq_enables;                 // Mask register
   reg        cmp_a_flag;                        // Compare A flag
   reg        cmp_b_flag;                        // Compare B flag
   reg        overflow_flag;                     // Overflow flag
   reg        count_down;                        // Phase-correct direction
   reg        block_match;                       // Match blocked after write
   reg  [7:0] next_counter;                      // Counter after tick
   reg        next_down;                         // Direction after tick
   reg        ovf_event;                         // Overflow on this tick
   reg  [7:0] top;                               // Current top
   wire       tick;                              // Timer clock enable
   wire [2:0] wave_mode;                         // Full wave mode
   wire       pwm_mode;                          // Any PWM mode
   wire       is_fast;                           // Fast PWM mode
   wire       is_pc;                             // Phase-correct mode
   wire       match_a;                           // Counter equals A
   wire       match_b;                           // Counter equals B
   wire       hit_a;                             // Live match event A
   wire       hit_b;                             // Live match event B
   wire       wr_ctrl_b;                         // Control B written
   wire       wr_flags;                          // Flag register written
   wire       force_a;                           // Force strobe A
   wire       force_b;                           // Force strobe B

   assign wave_mode = {wave_mode_msb, i_wave_mode_low};
   assign is_fast   = (wave_mode == `WM_FAST_FF) | (wave_mode == `WM_FAST_A);  // see [R15]
   assign is_pc     = (wave_mode == `WM_PC_FF) | (wave_mode == `WM_PC_A);      // see [R15]
   assign pwm_mode  = is_fast | is_pc;
   assign wr_ctrl_b = i_wr & (i_addr == `OFS_CTRL_B);
   assign wr_flags  = i_wr & (i_addr == `OFS_FLAGS);
   // Force only in non-PWM modes; software keeps them zero otherwise
   assign force_a   = wr_ctrl_b & i_wdata[`BIT_FORCE_A] & ~pwm_mode;      // see [R01]
   assign force_b   = wr_ctrl_b & i_wdata[`BIT_FORCE_B] & ~pwm_mode;      // see [R01]
   assign match_a   = (counter_value == compare_value_a);                 // see [R08]
   assign match_b   = (counter_value == compare_value_b);                 // see [R08]
   // Match acts once per timer tick; a counter write blocks the next one
   assign hit_a     = tick & match_a & ~block_match;                      // see [R07]
   assign hit_b     = tick & match_b & ~block_match;                      // see [R07]
   assign o_wave_en_a = |i_out_mode_a;
   assign o_wave_en_b = |i_out_mode_b;

   // ==================================================================
   // Prescaler
   timer0_prescaler u_prescaler (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_sel      (clk_source_sel),                                       // see [R05]
      .i_ext_pin  (i_ext_count_pin),                                      // see [R06]
      .o_tick     (tick)
   );

   // ==================================================================
   // Next counter value per wave mode
   always @* begin
      top       = ((wave_mode == `WM_CTC) | (wave_mode == `WM_PC_A) |
                   (wave_mode == `WM_FAST_A)) ? compare_value_a : `TOP_MAX;
      next_down = count_down;
      ovf_event = 1'b0;
      if (is_pc) begin
         // Up to top, then down to bottom; overflow at bottom
         if (!count_down) begin
            if (counter_value == top) begin
               next_counter = counter_value - 8'h01;
               next_down    = 1'b1;
            end else begin
               next_counter = counter_value + 8'h01;
            end
         end else begin
            if (counter_value == `ZERO8) begin
               next_counter = counter_value + 8'h01;
               next_down    = 1'b0;
               ovf_event    = 1'b1;                                       // see [R12]
            end else begin
               next_counter = counter_value - 8'h01;
            end
         end
      end else if (counter_value == top) begin
         // Wrap to bottom; overflow at max, or at top in fast-to-A
         next_counter = `ZERO8;
         ovf_event    = (wave_mode == `WM_FAST_A) | (counter_value == `TOP_MAX); // see [R12]
      end else begin
         // Counter above a lower top still wraps at max
         next_counter = counter_value + 8'h01;
         ovf_event    = (counter_value == `TOP_MAX);                      // see [R12]
      end
   end

   // ==================================================================
   // Counter, direction and match blocking
   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         counter_value <= `ZERO8;
         count_down    <= 1'b0;
         block_match   <= 1'b0;
      end else if (i_wr && i_addr == `OFS_COUNTER) begin
         counter_value <= i_wdata;                                        // see [R07]
         block_match   <= 1'b1;
      end else if (tick) begin
         counter_value <= next_counter;
         count_down    <= next_down;
         block_match   <= 1'b0;
      end
   end

   // ==================================================================
   // Software registers
   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         compare_value_a   <= `ZERO8;
         compare_value_b   <= `ZERO8;
         wave_mode_msb     <= 1'b0;
         clk_source_sel    <= `CS_STOP;
         timer_irq_enables <= `ZERO8;
      end else if (i_wr) begin
         case (i_addr)
            `OFS_CMP_A:   compare_value_a <= i_wdata;
            `OFS_CMP_B:   compare_value_b <= i_wdata;
            `OFS_CTRL_B: begin
               wave_mode_msb  <= i_wdata[`BIT_WAVE_MSB];                  // see [R14]
               clk_source_sel <= i_wdata[2:0];                            // see [R14]
            end
            // Only our three enable bits are stored
            `OFS_ENABLES: timer_irq_enables <= i_wdata & `IRQ_MASK;       // see [R13]
            default: begin
            end
         endcase
      end
   end

   // ==================================================================
   // Flags: hardware set takes priority over any clear
   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         cmp_a_flag    <= 1'b0;
         cmp_b_flag    <= 1'b0;
         overflow_flag <= 1'b0;
      end else begin
         // Force strobes never reach the flags
         if (hit_a)                                                       // see [R02] see [R16]
            cmp_a_flag <= 1'b1;                                           // see [R10]
         else if (i_vec_ack_a | (wr_flags & i_wdata[`BIT_CMP_A]))
            cmp_a_flag <= 1'b0;                                           // see [R10]
         if (hit_b)                                                       // see [R16]
            cmp_b_flag <= 1'b1;                                           // see [R11]
         else if (i_vec_ack_b | (wr_flags & i_wdata[`BIT_CMP_B]))
            cmp_b_flag <= 1'b0;                                           // see [R11]
         if (tick & ovf_event)                                            // see [R16]
            overflow_flag <= 1'b1;                                        // see [R12]
         else if (i_vec_ack_ovf | (wr_flags & i_wdata[`BIT_OVF]))
            overflow_flag <= 1'b0;                                        // see [R12]
      end
   end

   // ==================================================================
   // Interrupt requests
   assign o_irq_cmp_a = i_global_irq_en & timer_irq_enables[`BIT_CMP_A] & cmp_a_flag; // see [R09]
   assign o_irq_cmp_b = i_global_irq_en & timer_irq_enables[`BIT_CMP_B] & cmp_b_flag; // see [R09]
   assign o_irq_ovf   = i_global_irq_en & timer_irq_enables[`BIT_OVF] & overflow_flag; // see [R09]
   assign o_irq       = o_irq_cmp_a | o_irq_cmp_b | o_irq_ovf;

   // ==================================================================
   // Waveform outputs; forced matches act like live ones
   task automatic apply_mode;
      input  [1:0] mode;
      input        cur;
      input        up;
      output       res;
      begin
         if (pwm_mode) begin
            // PWM: clear/set on match, inverse when counting down
            res = (mode[1]) ? (mode[0] ^ ~up) : cur;
         end else begin
            case (mode)
               2'h1:    res = ~cur;
               2'h2:    res = 1'b0;
               2'h3:    res = 1'b1;
               default: res = cur;
            endcase
         end
      end
   endtask

   reg next_wave_a;                              // Next output A
   reg next_wave_b;                              // Next output B

   // Output action per channel
   always @* begin
      next_wave_a = o_wave_out_a;
      next_wave_b = o_wave_out_b;
      if (hit_a | force_a)                                                // see [R01]
         apply_mode(i_out_mode_a, o_wave_out_a, ~count_down, next_wave_a);
      else if (tick & is_fast & i_out_mode_a[1] & (next_counter == `ZERO8))
         next_wave_a = ~i_out_mode_a[0];         // Bottom restores in fast PWM
      if (hit_b | force_b)                                                // see [R01]
         apply_mode(i_out_mode_b, o_wave_out_b, ~count_down, next_wave_b);
      else if (tick & is_fast & i_out_mode_b[1] & (next_counter == `ZERO8))
         next_wave_b = ~i_out_mode_b[0];
   end

   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_wave_out_a <= 1'b0;
         o_wave_out_b <= 1'b0;
      end else begin
         o_wave_out_a <= next_wave_a;
         o_wave_out_b <= next_wave_b;
      end
   end

   // ==================================================================
   // Read port, data one cycle after the strobe
   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_rdata <= `ZERO8;
      end else if (i_rd) begin
         case (i_addr)
            `OFS_COUNTER: o_rdata <= counter_value;
            `OFS_CMP_A:   o_rdata <= compare_value_a;
            `OFS_CMP_B:   o_rdata <= compare_value_b;
            // Force bits and reserved bits read zero
            `OFS_CTRL_B:  o_rdata <= {4'h0, wave_mode_msb, clk_source_sel} & `CTRL_B_RMASK; // see [R03] see [R13]
            `OFS_ENABLES: o_rdata <= timer_irq_enables;                    // see [R13]
            `OFS_FLAGS:   o_rdata <= {3'h0, cmp_a_flag, cmp_b_flag, 1'b0, overflow_flag, 1'b0}; // see [R13]
            default:      o_rdata <= `ZERO8;
         endcase
      end else begin
         o_rdata <= `ZERO8;
      end
   end
endmodule // timer0_ctrl_flags_regs
`default_nettype wire

// ==== shared/timer0_consts.vh ====
`ifndef TIMER0_CONSTS_VH
`define TIMER0_CONSTS_VH
// Register offsets
`define OFS_CMP_B      8'h28
`define OFS_CTRL_B     8'h33
`define OFS_FLAGS      8'h38
`define OFS_ENABLES    8'h39
`define OFS_COUNTER    8'h32
`define OFS_CMP_A      8'h36
`define OFS_CTRL_A     8'h2A
// Field positions
`define BIT_FORCE_A    7
`define BIT_FORCE_B    6
`define BIT_WAVE_MSB   3
`define BIT_CMP_A      4
`define BIT_CMP_B      3
`define BIT_OVF        1
`define CTRL_B_RMASK   8'h0F
`define IRQ_MASK       8'h1A
// Values
`define ZERO8          8'h00
`define TOP_MAX        8'hFF
// Wave modes
`define WM_NORMAL      3'h0
`define WM_PC_FF       3'h1
`define WM_CTC         3'h2
`define WM_FAST_FF     3'h3
`define WM_PC_A        3'h5
`define WM_FAST_A      3'h7
// Clock select codes
`define CS_STOP        3'h0
`define CS_DIV1        3'h1
`define CS_DIV8        3'h2
`define CS_DIV64       3'h3
`define CS_DIV256      3'h4
`define CS_DIV1024     3'h5
`define CS_EXT_FALL    3'h6
`define CS_EXT_RISE    3'h7
`endif

// ==== hdl/timer0_prescaler.v ====
`timescale 1ns/1ps
`default_nettype none
`include "timer0_consts.vh"
// =====================================================================
// Prescaler and external count pin edge detector
module timer0_prescaler #(
   parameter DIV_W = 10                          // Prescaler width
) (
   input  wire       i_core_clk,                 // Core clock
   input  wire       i_reset,                    // Async reset, high
   input  wire [2:0] i_sel,                      // Clock source select
   input  wire       i_ext_pin,                  // External count pin
   output reg        o_tick                      // One-cycle count enable
);
   reg  [DIV_W-1:0] div_count;                   // Free-running divider
   reg              ext_meta;                    // Sync stage 1
   reg              ext_sync;                    // Sync stage 2
   reg              ext_prev;                    // Previous synced level
   reg              next_tick;                   // Combined tick
   wire [DIV_W-1:0] div_inc;                     // Divider plus one
   assign div_inc = div_count + {{(DIV_W-1){1'b0}}, 1'b1};

   // Divider and pin synchroniser; pin is read even when driven as output
   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         div_count <= {DIV_W{1'b0}};
         ext_meta  <= 1'b0;
         ext_sync  <= 1'b0;
         ext_prev  <= 1'b0;
         o_tick    <= 1'b0;
      end else begin
         div_count <= div_inc;
         ext_meta  <= i_ext_pin;
         ext_sync  <= ext_meta;
         ext_prev  <= ext_sync;
         o_tick    <= next_tick;
      end
   end

   // Tap select: a tap fires when low bits of next count wrap to zero
   always @* begin
      case (i_sel)
         `CS_STOP:     next_tick = 1'b0;
         `CS_DIV1:     next_tick = 1'b1;
         `CS_DIV8:     next_tick = (div_inc[2:0] == 3'h0);
         `CS_DIV64:    next_tick = (div_inc[5:0] == 6'h00);
         `CS_DIV256:   next_tick = (div_inc[7:0] == 8'h00);
         `CS_DIV1024:  next_tick = (div_inc[9:0] == 10'h000);
         `CS_EXT_FALL: next_tick = ext_prev & ~ext_sync;
         `CS_EXT_RISE: next_tick = ~ext_prev & ext_sync;
         default:      next_tick = 1'b0;
      endcase
   end
endmodule // timer0_prescaler
`default_nettype wire

// ==== sim/timer0_regs_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "timer0_consts.vh"
// ============================================================
// Port checker for the timer register block
module timer0_regs_sva (
   input wire logic       i_core_clk,      // Clock
   input wire logic       i_reset,         // Reset
   input wire logic [7:0] i_addr,          // Address
   input wire logic [7:0] i_wdata,         // Write data
   input wire logic       i_wr,            // Write strobe
   input wire logic       i_rd,            // Read strobe
   input wire logic [7:0] o_rdata,         // Read data
   input wire logic [1:0] i_out_mode_a,    // Mode A
   input wire logic [1:0] i_out_mode_b,    // Mode B
   input wire logic [1:0] i_wave_mode_low, // Low wave bits
   input wire logic       i_global_irq_en, // Global bit
   input wire logic       o_wave_out_a,    // Wave A
   input wire logic       o_wave_out_b,    // Wave B
   input wire logic       o_irq_cmp_a,     // Request A
   input wire logic       o_irq_cmp_b,     // Request B
   input wire logic       o_irq_ovf,       // Request overflow
   input wire logic       o_irq            // Combined level
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   logic       msb_q;                      // Tracked wave msb
   logic       sel_nz;                     // Counting selected
   logic [1:0] idle;                       // Cycles fully stopped
   wire        ctl_wr = i_wr && (i_addr == `OFS_CTRL_B);
   // Track control B; a tick may still be in flight after a stop
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         msb_q  <= 1'b0;
         sel_nz <= 1'b0;
         idle   <= 2'd3;
      end else begin
         if (ctl_wr) begin
            msb_q  <= i_wdata[3];
            sel_nz <= |i_wdata[2:0];
         end
         if (sel_nz || (ctl_wr && |i_wdata[2:0])) idle <= 2'd0;
         else if (idle != 2'd3) idle <= idle + 2'd1;
      end
   end
   // ============================================================
   // Force strobe classification
   sequence s_force_np(int b);
      ctl_wr && i_wdata[b] && !i_wdata[3] && !msb_q && !i_wave_mode_low[0];
   endsequence
   sequence s_force_pwm;
      ctl_wr && i_wdata[7] && i_wave_mode_low[0] && i_wdata[2:0] == 3'd0 && idle == 2'd3;
   endsequence
   // ============================================================
   // Assertions
   a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data not zero outside read");
   a_ctrl_read_mask: assert property ($past(i_rd) && $past(i_addr) == `OFS_CTRL_B |-> o_rdata[7:4] == 4'h0)
      else $error("control force or reserved bits read nonzero");
   a_flag_read_resvd: assert property ($past(i_rd) && ($past(i_addr) == `OFS_FLAGS || $past(i_addr) == `OFS_ENABLES)
      |-> (o_rdata & ~`IRQ_MASK) == 8'h00)
      else $error("reserved flag or mask bit read nonzero");
   a_irq_is_or: assert property (o_irq == (o_irq_cmp_a | o_irq_cmp_b | o_irq_ovf))
      else $error("combined interrupt differs from requests");
   a_irq_global_gate: assert property (!i_global_irq_en |-> !o_irq_cmp_a && !o_irq_cmp_b && !o_irq_ovf)
      else $error("request without global bit");
   a_irq_enable_gate: assert property (i_wr && i_addr == `OFS_ENABLES && i_wdata == 8'h00 |=> !o_irq[*2])
      else $error("request with all enables clear");
   a_force_a_set: assert property (s_force_np(7) ##0 i_out_mode_a == 2'b11 |=> o_wave_out_a)
      else $error("forced set on output A missing");
   a_force_b_clear: assert property (s_force_np(6) ##0 i_out_mode_b == 2'b10 |=> !o_wave_out_b)
      else $error("forced clear on output B missing");
   a_force_pwm_hold: assert property (s_force_pwm |=> $stable(o_wave_out_a))
      else $error("force acted in a PWM mode");
endmodule // timer0_regs_sva

bind timer0_ctrl_flags_regs timer0_regs_sva i_sva (.*);
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "timer0_consts.vh"
// ============================================================
// Self-checking bench for the timer register block
module tb;
   logic       i_core_clk = 1'b0;       // 250 MHz clock
   logic       i_reset = 1'b1;          // Held 16 cycles
   logic [7:0] i_addr = 8'h00;          // Bus address
   logic [7:0] i_wdata = 8'h00;         // Bus write data
   logic       i_wr = 1'b0;             // Write strobe
   logic       i_rd = 1'b0;             // Read strobe
   logic [1:0] i_out_mode_a = 2'b00;    // Output mode A
   logic [1:0] i_out_mode_b = 2'b00;    // Output mode B
   logic [1:0] i_wave_mode_low = 2'b00; // Low wave bits
   logic       i_global_irq_en = 1'b0;  // Global bit
   logic       i_vec_ack_a = 1'b0;      // Vector taken A
   logic       i_vec_ack_b = 1'b0;      // Vector taken B
   logic       i_vec_ack_ovf = 1'b0;    // Vector taken overflow
   logic       i_ext_count_pin = 1'b0;  // Count pin
   wire  [7:0] o_rdata;
   wire        o_wave_out_a;
   wire        o_wave_out_b;
   wire        o_wave_en_a;
   wire        o_wave_en_b;
   wire        o_irq_cmp_a;
   wire        o_irq_cmp_b;
   wire        o_irq_ovf;
   wire        o_irq;
   integer     n_errors = 0;            // Mismatches
   integer     samples_checked = 0;     // Comparisons
   integer     seed = 32'h225d;         // Fixed seed
   integer     k;
   integer     c;
   logic [7:0] a;
   logic [7:0] d;
   logic [7:0] offs [6] = '{`OFS_CMP_B, `OFS_CTRL_B, `OFS_FLAGS, `OFS_ENABLES, `OFS_COUNTER, `OFS_CMP_A};

   timer0_ctrl_flags_regs i_dut (.*);

   // Clock, 4 ns period
   always #2 i_core_clk = ~i_core_clk;

   // ============================================================
   // Expectations
   function automatic logic [7:0] rmask(input logic [7:0] ad);
      if (ad == `OFS_CTRL_B) return `CTRL_B_RMASK;
      if (ad == `OFS_ENABLES) return `IRQ_MASK;
      return 8'hFF;
   endfunction
   // Toggle, clear or set, by output mode
   function automatic logic fexp(input logic [1:0] m, input logic cur);
      return (m == 2'b01) ? ~cur : m[0];
   endfunction
   function automatic integer divof(input integer cs);
      case (cs)
         1: return 1;
         2: return 8;
         3: return 64;
         4: return 256;
         default: return 1024;
      endcase
   endfunction

   // ============================================================
   // Bus and compare tasks
   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      @(posedge i_core_clk);
      i_wr <= 1'b1;
      i_addr <= ad;
      i_wdata <= dt;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
      #1;
   endtask
   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
      @(posedge i_core_clk);
      i_rd <= 1'b1;
      i_addr <= ad;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1;
      dt = o_rdata;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] ad, input logic [7:0] exp);
      logic [7:0] got;
      rd(ad, got);
      chk(got, exp);
   endtask
   // Count at full rate for n cycles, then stop
   task automatic run(input integer n);
      wr(`OFS_CTRL_B, 8'h01);
      repeat (n) @(posedge i_core_clk);
      wr(`OFS_CTRL_B, 8'h00);
   endtask
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial begin
      #100000;
      n_errors++;
      $display("BAD t=%0t watchdog expired", $time);
      report_and_stop;
   end

   // ============================================================
   // Main sequence
   initial begin
      repeat (16) @(posedge i_core_clk);
      i_reset <= 1'b0;
      for (k = 0; k < 6; k++) rdc(offs[k], 8'h00);
      chk(8'({o_wave_en_a, o_wave_en_b}), 8'h00);
      wr(8'h00, 8'hA5);
      rdc(8'h00, 8'h00);
      for (k = 0; k < 30; k++) begin
         a = offs[$unsigned($random(seed)) % 6];
         d = 8'($random(seed));
         if (a == `OFS_CTRL_B) d[2:0] = 3'b000;
         if (a == `OFS_FLAGS) a = `OFS_COUNTER;
         wr(a, d);
         rdc(a, d & rmask(a));
      end
      $display("test registers done");
      for (c = 1; c < 6; c++) begin
         wr(`OFS_COUNTER, 8'h00);
         wr(`OFS_CTRL_B, 8'(c));
         repeat (4 * divof(c)) @(posedge i_core_clk);
         wr(`OFS_CTRL_B, 8'h00);
         rd(`OFS_COUNTER, d);
         chk(8'(d >= 8'd3 && d <= 8'd7), 8'h01);
      end
      wr(`OFS_COUNTER, 8'h21);
      repeat (50) @(posedge i_core_clk);
      rdc(`OFS_COUNTER, 8'h21);
      for (c = 6; c < 8; c++) begin
         wr(`OFS_COUNTER, 8'h00);
         wr(`OFS_CTRL_B, 8'(c));
         for (k = 0; k < 11; k++) begin
            i_ext_count_pin <= ~i_ext_count_pin;
            repeat (4) @(posedge i_core_clk);
         end
         repeat (8) @(posedge i_core_clk);
         wr(`OFS_CTRL_B, 8'h00);
         i_ext_count_pin <= 1'b0;
         rdc(`OFS_COUNTER, (c == 7) ? 8'h06 : 8'h05);
      end
      $display("test clock select done");
      wr(`OFS_FLAGS, 8'hFF);
      rdc(`OFS_FLAGS, 8'h00);
      wr(`OFS_CMP_A, 8'hF5);
      wr(`OFS_CMP_B, 8'hFA);
      wr(`OFS_COUNTER, 8'hF0);
      wr(`OFS_ENABLES, 8'h1A);
      i_global_irq_en <= 1'b1;
      run(40);
      rdc(`OFS_FLAGS, 8'h1A);
      chk(8'({o_irq, o_irq_cmp_a, o_irq_cmp_b, o_irq_ovf}), 8'h0F);
      wr(`OFS_ENABLES, 8'h10);
      chk(8'({o_irq, o_irq_cmp_a, o_irq_cmp_b, o_irq_ovf}), 8'h0C);
      i_global_irq_en <= 1'b0;
      @(posedge i_core_clk);
      #1;
      chk(8'(o_irq), 8'h00);
      i_global_irq_en <= 1'b1;
      wr(`OFS_FLAGS, 8'h10);
      rdc(`OFS_FLAGS, 8'h0A);
      i_vec_ack_b <= 1'b1;
      @(posedge i_core_clk);
      i_vec_ack_b <= 1'b0;
      rdc(`OFS_FLAGS, 8'h02);
      i_vec_ack_ovf <= 1'b1;
      @(posedge i_core_clk);
      i_vec_ack_ovf <= 1'b0;
      rdc(`OFS_FLAGS, 8'h00);
      $display("test flags done");
      wr(`OFS_CMP_A, 8'h40);
      wr(`OFS_COUNTER, 8'h40);
      run(20);
      rdc(`OFS_FLAGS, 8'h00);
      wr(`OFS_COUNTER, 8'h3E);
      run(20);
      rdc(`OFS_FLAGS, 8'h10);
      i_vec_ack_a <= 1'b1;
      @(posedge i_core_clk);
      i_vec_ack_a <= 1'b0;
      rdc(`OFS_FLAGS, 8'h00);
      $display("test counter write done");
      for (k = 1; k < 4; k++) begin
         i_out_mode_a <= 2'(k);
         i_out_mode_b <= 2'(4 - k);
         @(posedge i_core_clk);
         #1;
         d = {6'b0, fexp(2'(k), o_wave_out_a), fexp(2'(4 - k), o_wave_out_b)};
         wr(`OFS_CTRL_B, 8'hC0);
         chk({6'b0, o_wave_out_a, o_wave_out_b}, d);
         chk(8'({o_wave_en_a, o_wave_en_b}), 8'h03);
      end
      rdc(`OFS_FLAGS, 8'h00);
      i_wave_mode_low <= 2'b10;
      wr(`OFS_CMP_A, 8'h55);
      wr(`OFS_COUNTER, 8'h55);
      wr(`OFS_CTRL_B, 8'hC0);
      rdc(`OFS_COUNTER, 8'h55);
      rdc(`OFS_FLAGS, 8'h00);
      i_out_mode_a <= 2'b10;
      wr(`OFS_CTRL_B, 8'h80);
      i_wave_mode_low <= 2'b11;
      i_out_mode_a <= 2'b11;
      wr(`OFS_CTRL_B, 8'h80);
      chk(8'(o_wave_out_a), 8'h00);
      wr(`OFS_ENABLES, 8'h00);
      $display("test force strobes done");
      report_and_stop;
   end
endmodule // tb
`default_nettype wire
